/* hw/scpoc_defines.svh */
`ifndef SCPOC_DEFINES_SVH
`define SCPOC_DEFINES_SVH
// ==========================================
// register byte offsets
`define SCPOC_OFS_CTRL 8'h00
`define SCPOC_OFS_MSTP 8'h04
`define SCPOC_OFS_STAT 8'h08
`define SCPOC_OFS_PEND 8'h0C
// ==========================================
// control register fields
`define SCPOC_CTRL_STOP_BIT 0
`define SCPOC_CTRL_DIR_BIT 1
`define SCPOC_CTRL_DIV_LSB 2
`define SCPOC_CTRL_DIV_MSB 4
// ==========================================
// stop control fields and reset values
`define SCPOC_MSTP_DMA_BIT 14
`define SCPOC_MSTP_DTC_BIT 13
`define SCPOC_MSTP_RESET 16'h9FFF
`define SCPOC_EXT_RESET 16'hFFFF
`define SCPOC_CTRL_RESET 5'h00
// ==========================================
// timing
`define SCPOC_MCLK_KHZ 20000
`define SCPOC_MIN_PHI_KHZ 8000
`define SCPOC_STBY_WAIT_TICKS 64
`endif

/* hw/scpoc_pkg.sv */
package scpoc_pkg;
  // processing state of the device, driven by the power controller
  typedef enum logic [2:0] {
    SCPOC_NORMAL,
    SCPOC_SLEEP,
    SCPOC_SW_STBY,
    SCPOC_HW_STBY,
    SCPOC_ALL_STOP
  } scpoc_mode_t;
  typedef logic [2:0] scpoc_div_t;
endpackage : scpoc_pkg

/* hw/scpoc_div.sv */
`timescale 1ns/1ps
// ==========================================
// divided system clock generator: half period of 2**sel cycles
module scpoc_div
#(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // control
  input wire scpoc_pkg::scpoc_div_t sel,
  // divided clock
  output logic phase,
  output logic rise,
  output logic fall
);
  import scpoc_pkg::*;
  logic [CNT_W-1:0] cnt_ff;
  logic phase_ff;
  logic [CNT_W-1:0] limit;
  logic tick;

  assign limit = CNT_W'((1 << sel) - 1);
  assign tick = (cnt_ff >= limit);
  assign rise = ce & tick & ~phase_ff;
  assign fall = ce & tick & phase_ff;
  assign phase = phase_ff;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_ff <= '0;
    else if (ce)
      cnt_ff <= tick ? '0 : cnt_ff + CNT_W'(1);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      phase_ff <= 1'b0;
    else if (ce && tick)
      phase_ff <= ~phase_ff;
  end
endmodule : scpoc_div

/* hw/scpoc_top.sv */
// Functional notes
// - stop bit 1 halts clock output at bus cycle end, pin driven high
// - stop bit 0 with direction output lets the clock toggle on the pin
// - direction 0 disables clock output, pin becomes an input
// - pin state follows direction, stop bit and processing state table
// - software standby holds every general port output at its previous level; the clock pin stops high
// - dma/transfer controller stop bits refused while that controller is active
// - stopped peripheral: no interrupt operation, pending sources cannot be cleared
// - clock pin output and standby release wait run from the divided clock
`timescale 1ns/1ps
`include "scpoc_defines.svh"
module scpoc_top #(
  parameter int NPORT = 8,
  parameter int NMOD = 16,
  parameter int WAIT_TICKS = `SCPOC_STBY_WAIT_TICKS
) (
  // clock, reset, enable
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // processing state and bus timing
  input wire scpoc_pkg::scpoc_mode_t PROC_STATE,
  input wire logic BUS_CYC_END,
  // transfer engines
  input wire logic DMA_ACTIVE,
  input wire logic DTC_ACTIVE,
  // clock output pin
  output logic CLK_PIN_O,
  output logic CLK_PIN_OE,
  // general ports
  input wire logic [NPORT-1:0] PORT_DATA,
  input wire logic [NPORT-1:0] PORT_DIR,
  output logic [NPORT-1:0] PORT_O,
  output logic [NPORT-1:0] PORT_OE,
  // peripheral stop and interrupts
  input wire logic [NMOD-1:0] IRQ_REQ,
  input wire logic [NMOD-1:0] IRQ_CLR,
  output logic [NMOD-1:0] MOD_STOP,
  output logic [15:0] EXT_STOP,
  output logic [NMOD-1:0] IRQ_OUT,
  output logic WAKE_READY
);
  import scpoc_pkg::*;

  // ==========================================
  // helpers
  function automatic logic ratio_ok(input scpoc_div_t sel);
    ratio_ok = ((`SCPOC_MCLK_KHZ >> ({1'b0, sel} + 4'h1)) >= `SCPOC_MIN_PHI_KHZ);
  endfunction : ratio_ok

  logic stop_bit_ff, dir_ff;
  scpoc_div_t div_ff;
  logic [NMOD-1:0] mstp_ff, pend_ff;
  logic [15:0] ext_ff;
  logic stop_act_ff, en_ff, pin_ff, oe_ff, wake_ff;
  logic [15:0] wake_cnt_ff;
  logic phase, rise, fall;
  logic acc, wr, hit;
  logic [31:0] rdata;
  logic want_run, in_hw, in_sw;

  assign in_hw = (PROC_STATE == SCPOC_HW_STBY);
  assign in_sw = (PROC_STATE == SCPOC_SW_STBY);

  // ==========================================
  // apb slave: one wait state, so every output is registered
  assign acc = PSEL & PENABLE & ~PREADY;
  assign wr = PSEL & PENABLE & PREADY & PWRITE & CE;
  assign hit = (PADDR == `SCPOC_OFS_CTRL) || (PADDR == `SCPOC_OFS_MSTP) ||
               (PADDR == `SCPOC_OFS_STAT) || (PADDR == `SCPOC_OFS_PEND);

  always_comb
  begin
    rdata = 32'h0000_0000;
    case (PADDR)
      `SCPOC_OFS_CTRL: rdata = {27'h0, div_ff, dir_ff, stop_bit_ff};
      `SCPOC_OFS_MSTP: rdata = {ext_ff, 16'(mstp_ff)};
      `SCPOC_OFS_STAT: rdata = {24'h0, 1'(PROC_STATE == SCPOC_ALL_STOP), wake_ff,
                                stop_act_ff, en_ff, oe_ff, pin_ff, DTC_ACTIVE, DMA_ACTIVE};
      `SCPOC_OFS_PEND: rdata = {16'h0, 16'(pend_ff)};
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else if (CE)
    begin
      PREADY <= acc;
      PSLVERR <= acc & ~hit;
      if (acc && !PWRITE)
        PRDATA <= rdata;
    end
  end

  // ==========================================
  // clock control register; a too-slow ratio is refused, old value kept
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      {div_ff, dir_ff, stop_bit_ff} <= `SCPOC_CTRL_RESET;
    else if (wr && PADDR == `SCPOC_OFS_CTRL)
    begin
      stop_bit_ff <= PWDATA[`SCPOC_CTRL_STOP_BIT];
      dir_ff <= PWDATA[`SCPOC_CTRL_DIR_BIT];
      if (ratio_ok(PWDATA[`SCPOC_CTRL_DIV_MSB:`SCPOC_CTRL_DIV_LSB]))
        div_ff <= PWDATA[`SCPOC_CTRL_DIV_MSB:`SCPOC_CTRL_DIV_LSB];
    end
  end

  // ==========================================
  // stop control registers
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      mstp_ff <= NMOD'(`SCPOC_MSTP_RESET);
      ext_ff <= `SCPOC_EXT_RESET;
    end
    else if (wr && PADDR == `SCPOC_OFS_MSTP)
    begin
      mstp_ff <= PWDATA[NMOD-1:0];
      ext_ff <= PWDATA[31:16];
      // an engine in the middle of a transfer cannot be stopped
      if (DMA_ACTIVE && !mstp_ff[`SCPOC_MSTP_DMA_BIT])
        mstp_ff[`SCPOC_MSTP_DMA_BIT] <= 1'b0;
      if (DTC_ACTIVE && !mstp_ff[`SCPOC_MSTP_DTC_BIT])
        mstp_ff[`SCPOC_MSTP_DTC_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      MOD_STOP <= NMOD'(`SCPOC_MSTP_RESET);
      EXT_STOP <= `SCPOC_EXT_RESET;
    end
    else if (CE && BUS_CYC_END)
    begin
      MOD_STOP <= mstp_ff;
      EXT_STOP <= ext_ff;
    end
  end

  // ==========================================
  // interrupt pending: set wins over clear; no clear while stopped
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      pend_ff <= '0;
      IRQ_OUT <= '0;
    end
    else if (CE)
    begin
      pend_ff <= ((pend_ff & ~(IRQ_CLR & ~MOD_STOP)) | (IRQ_REQ & ~MOD_STOP));
      IRQ_OUT <= pend_ff & ~MOD_STOP;
    end
  end

  // ==========================================
  // divided clock; the clock pin and standby release wait strobes come from it
  scpoc_div #(.CNT_W(8)) u_div (
    .clk(MCLK),
    .arst_n(ARST_N),
    .ce(CE),
    .sel(div_ff),
    .phase(phase),
    .rise(rise),
    .fall(fall)
  );

  // stop bit acts only at bus cycle end
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      stop_act_ff <= 1'b1;
    else if (CE && BUS_CYC_END)
      stop_act_ff <= stop_bit_ff;
  end

  assign want_run = ~stop_act_ff & dir_ff & ~in_sw & ~in_hw;

  // enable changes only where the clock goes high, so no phase is cut short
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      en_ff <= 1'b0;
    else if (rise)
      en_ff <= want_run;
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      pin_ff <= 1'b1;
    else if (rise)
      pin_ff <= 1'b1;
    else if (fall)
      pin_ff <= ~en_ff;
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      oe_ff <= 1'b0;
    else if (CE)
      oe_ff <= dir_ff & ~in_hw;
  end

  assign CLK_PIN_O = pin_ff;
  assign CLK_PIN_OE = oe_ff;

  // ==========================================
  // ports: frozen in software standby, released in hardware standby
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PORT_O <= '0;
      PORT_OE <= '0;
    end
    else if (CE && !in_sw)
    begin
      PORT_O <= PORT_DATA;
      PORT_OE <= in_hw ? '0 : PORT_DIR;
    end
  end

  // ==========================================
  // standby release wait, counted in divided clock periods
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      wake_cnt_ff <= '0;
      wake_ff <= 1'b1;
    end
    else if (CE)
    begin
      if (in_sw || in_hw)
      begin
        wake_cnt_ff <= '0;
        wake_ff <= 1'b0;
      end
      else if (!wake_ff && rise)
      begin
        wake_cnt_ff <= wake_cnt_ff + 16'h0001;
        if (wake_cnt_ff == 16'(WAIT_TICKS - 1))
          wake_ff <= 1'b1;
      end
    end
  end

  assign WAKE_READY = wake_ff;

  // ==========================================
  // checks
  a_stopped_pin_high: assert property (@(posedge MCLK) disable iff (!ARST_N)
    !en_ff |-> CLK_PIN_O) else $error("clock pin not high while stopped");
  a_dir_input_hiz: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (CE && !dir_ff) |=> !CLK_PIN_OE) else $error("clock pin driven with direction input");
  a_hw_stby_hiz: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (CE && in_hw) |=> (!CLK_PIN_OE && PORT_OE == '0)) else $error("pin driven in hardware standby");
  a_run_needs_dir: assert property (@(posedge MCLK) disable iff (!ARST_N)
    $rose(en_ff) |-> ($past(dir_ff) && !$past(stop_act_ff))) else $error("clock started without enable");
  a_port_hold: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (in_sw ##1 in_sw) |-> $stable(PORT_O)) else $error("port output changed in standby");
  a_engine_stop_refuse: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (wr && PADDR == `SCPOC_OFS_MSTP && DMA_ACTIVE && !mstp_ff[`SCPOC_MSTP_DMA_BIT])
    |=> !mstp_ff[`SCPOC_MSTP_DMA_BIT]) else $error("dma stop accepted while active");
  a_no_clear_stopped: assert property (@(posedge MCLK) disable iff (!ARST_N)
    CE |=> ((pend_ff & $past(pend_ff & MOD_STOP)) == $past(pend_ff & MOD_STOP)))
    else $error("pending source cleared while stopped");
  a_ratio_floor: assert property (@(posedge MCLK) disable iff (!ARST_N)
    ratio_ok(div_ff)) else $error("divided clock below minimum");
  a_resume_edge: assert property (@(posedge MCLK) disable iff (!ARST_N)
    $changed(en_ff) |-> ($past(rise) && CLK_PIN_O)) else $error("clock enable changed mid phase");
  a_wake_wait: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (CE && in_sw) |=> !WAKE_READY [*2]) else $error("wake ready during standby");
endmodule : scpoc_top

/* testbench/scpoc_board.sv */
`timescale 1ns/1ps
// ==========================================
// board logic on the clock pin: pull-up, counts rising edges
module scpoc_board (
  // clock and control
  input wire logic clk,
  input wire logic clr,
  // clock pin
  input wire logic pin,
  input wire logic oe,
  // observed edges
  output int edges
);
  logic lvl;
  logic lvl_q = 1'b1;
  // a released pin floats to the pull-up level, never the last value
  assign lvl = oe ? pin : 1'b1;
  always @(posedge clk)
  begin
    lvl_q <= lvl;
    if (clr)
      edges <= 0;
    else if (lvl && !lvl_q)
      edges <= edges + 1;
  end
endmodule : scpoc_board

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import scpoc_pkg::*;
  logic mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic bce = 1'b0, dma = 1'b0, data_transfer_controller = 1'b0, clr = 1'b0, ce = 1'b1, pready, pslverr, pin, oe, wake, serr;
  logic [7:0] paddr = 8'h00, pdata = 8'h00, pdir = 8'h00, port_o, port_oe;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] irq_req = 16'h0, irq_clr = 16'h0, mod_stop, ext_stop, irq_out;
  scpoc_mode_t state = SCPOC_NORMAL;
  scpoc_mode_t run_m [3] = '{SCPOC_NORMAL, SCPOC_SLEEP, SCPOC_ALL_STOP};
  int errors = 0, n_compared = 0, cyc = 0, edges, e;
  always #25 mclk = ~mclk;
  scpoc_top #(.WAIT_TICKS(4)) dut (.MCLK(mclk), .ARST_N(arst_n), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PROC_STATE(state), .BUS_CYC_END(bce),
    .DMA_ACTIVE(dma), .DTC_ACTIVE(data_transfer_controller), .CLK_PIN_O(pin), .CLK_PIN_OE(oe), .PORT_DATA(pdata),
    .PORT_DIR(pdir), .PORT_O(port_o), .PORT_OE(port_oe), .IRQ_REQ(irq_req), .IRQ_CLR(irq_clr),
    .MOD_STOP(mod_stop), .EXT_STOP(ext_stop), .IRQ_OUT(irq_out), .WAKE_READY(wake));
  scpoc_board brd (.clk(mclk), .clr(clr), .pin(pin), .oe(oe), .edges(edges));
  // ==========================================
  // report and compare
  task wrap_up;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // ==========================================
  // apb master: holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_n(input int n);
    repeat (n) @(posedge mclk);
  endtask : wait_n
  task pulse;
    @(posedge mclk);
    bce <= 1'b1;
    @(posedge mclk);
    bce <= 1'b0;
    wait_n(4);
  endtask : pulse
  // rising edges seen by the board over 20 cycles
  task count(output int n);
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    wait_n(20);
    n = edges;
  endtask : count
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      wrap_up();
    end
  end
  // ==========================================
  // main sequence
  initial
  begin
    wait_n(16);
    arst_n <= 1'b1;
    wait_n(1);
    chk({ext_stop, mod_stop}, 32'hFFFF9FFF);
    chk({30'h0, oe, pin}, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], serr}, 32'h1);
    apb(1'b1, 8'h00, 32'h5);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    pulse();
    chk({30'h0, oe, pin}, 32'h1);
    apb(1'b1, 8'h00, 32'h2);
    pulse();
    foreach (run_m[i])
    begin
      state <= run_m[i];
      count(e);
      chk(32'(e inside {9, 10}), 32'h1);
      chk({31'h0, oe}, 32'h1);
    end
    // clock enable low freezes the divided clock, so the pin must not toggle
    ce <= 1'b0;
    count(e);
    chk(32'(e), 32'h0);
    ce <= 1'b1;
    pdir <= 8'hFF;
    pdata <= 8'hA5;
    wait_n(3);
    chk({port_oe, port_o}, 32'hFFA5);
    state <= SCPOC_SW_STBY;
    wait_n(4);
    pdata <= 8'h5A;
    count(e);
    chk(32'(e), 32'h0);
    chk({29'h0, wake, oe, pin}, 32'h3);
    chk({port_oe, port_o}, 32'hFFA5);
    state <= SCPOC_HW_STBY;
    wait_n(3);
    chk({port_oe, 6'h0, oe, pin}, 32'h1);
    state <= SCPOC_NORMAL;
    wait_n(30);
    chk({wake, port_o}, 32'h15A);
    apb(1'b1, 8'h00, 32'h3);
    pulse();
    count(e);
    chk({e[29:0], oe, pin}, 32'h3);
    @(posedge mclk);
    irq_req <= 16'h2001;
    @(posedge mclk);
    irq_req <= 16'h0000;
    wait_n(3);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h2000);
    chk(32'(irq_out), 32'h2000);
    data_transfer_controller <= 1'b1;
    dma <= 1'b1;
    apb(1'b1, 8'h04, 32'hFFFFFFFF);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'hFFFF9FFF);
    apb(1'b0, 8'h08, 32'h0);
    chk(32'(rd[1:0]), 32'h3);
    pulse();
    chk(32'(mod_stop), 32'h9FFF);
    data_transfer_controller <= 1'b0;
    dma <= 1'b0;
    apb(1'b1, 8'h04, 32'hFFFFFFFF);
    pulse();
    chk(32'(mod_stop), 32'hFFFF);
    @(posedge mclk);
    irq_clr <= 16'h2000;
    @(posedge mclk);
    irq_clr <= 16'h0000;
    wait_n(3);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h2000);
    chk(32'(irq_out), 32'h0);
    wrap_up();
  end
endmodule : tb_top
